/* design/broadcast_enable_pkg.sv */
// Shared constants for the charge parameter broadcast block
package broadcast_enable_pkg;

    // ****************************************
    // Frame codes
    // ****************************************
    localparam logic [6:0] SMB_CHARGER_ADDR = 7'h09;   // 0x12 as write byte
    localparam logic [7:0] CMD_CURRENT = 8'h14;
    localparam logic [7:0] CMD_VOLTAGE = 8'h15;
    localparam logic [15:0] VALUE_MAX = 16'hFFFE;      // 65,534 mV or mA
    localparam logic [7:0] CRC8_POLY = 8'h07;

    // ****************************************
    // Timing
    // ****************************************
    localparam int CLK_HZ = 250_000_000;
    localparam int SCL_KHZ = 100;
    localparam int QTR_CYCLES = CLK_HZ / (SCL_KHZ * 1000 * 4);
    localparam logic [15:0] QTR_CNT = 16'(QTR_CYCLES);
    localparam int PERIOD_MIN_S = 10;
    localparam int PERIOD_MAX_S = 60;
    localparam int SMB_PERIOD_S = 10;
    localparam longint SMB_PERIOD_CYC = longint'(SMB_PERIOD_S) * CLK_HZ;

    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [7:0] RST_BYTE = 8'h00;

endpackage : broadcast_enable_pkg

/* design/broadcast_enable_byte_tx.sv */
// Byte-level open-drain master engine: start, bytes, stop
`timescale 1ns/1ns
module broadcast_enable_byte_tx
    import broadcast_enable_pkg::*;
#(
    // Quarter of one bus clock period, in system clocks
    parameter logic [15:0] QTR_CYC = QTR_CNT
) (
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rstn,
    // Command
    input wire logic i_start,
    input wire logic i_send,
    input wire logic i_stop,
    input wire logic [7:0] i_byte,
    output logic o_busy,
    output logic o_nack,
    // Bus pins
    input wire logic i_scl,
    input wire logic i_sda,
    output logic o_scl_oe,
    output logic o_sda_oe
);
    typedef enum logic [4:0] {
        S_IDLE = 5'h01, S_START = 5'h02, S_BIT = 5'h04, S_ACK = 5'h08, S_STOP = 5'h10
    } st_e;

    st_e st_q;
    logic [15:0] div_q;
    logic [1:0] ph_q;
    logic [2:0] bit_q;
    logic [7:0] sh_q;
    logic nack_q;
    logic scl_oe_q;
    logic sda_oe_q;
    wire tick = (div_q == QTR_CYC - 16'h0001);
    wire active = (st_q != S_IDLE);

    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            div_q <= 16'h0000;
        end else begin
            div_q <= (tick || !active) ? 16'h0000 : div_q + 16'h0001;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            st_q <= S_IDLE;
            ph_q <= 2'h0;
            bit_q <= 3'h7;
            sh_q <= RST_BYTE;
            nack_q <= 1'b0;
            scl_oe_q <= 1'b0;
            sda_oe_q <= 1'b0;
        end else begin
            case (st_q)
                S_IDLE: begin
                    ph_q <= 2'h0;
                    bit_q <= 3'h7;
                    sh_q <= i_byte;
                    if (i_start) begin
                        st_q <= S_START;
                        nack_q <= 1'b0;
                    end else if (i_send) begin
                        st_q <= S_BIT;
                    end else if (i_stop) begin
                        st_q <= S_STOP;
                    end
                end
                S_START: if (tick) begin
                    ph_q <= ph_q + 2'h1;
                    if (ph_q == 2'h1) sda_oe_q <= 1'b1;
                    if (ph_q == 2'h3) begin
                        scl_oe_q <= 1'b1;
                        st_q <= S_IDLE;
                    end
                end
                S_BIT, S_ACK: if (tick) begin
                    ph_q <= ph_q + 2'h1;
                    // Data changes only while the clock is held low
                    // No arbitration loss check: sole master on the bus assumed
                    if (ph_q == 2'h0) sda_oe_q <= (st_q == S_BIT) ? !sh_q[7] : 1'b0;
                    if (ph_q == 2'h1) scl_oe_q <= 1'b0;
                    // Waits for a released clock: slaves may stretch it
                    if (ph_q == 2'h2 && !i_scl) ph_q <= 2'h2;
                    if (ph_q == 2'h2 && i_scl && st_q == S_ACK) nack_q <= i_sda;
                    if (ph_q == 2'h3) begin
                        scl_oe_q <= 1'b1;
                        if (st_q == S_ACK) begin
                            st_q <= S_IDLE;
                        end else begin
                            sh_q <= {sh_q[6:0], 1'b0};
                            bit_q <= bit_q - 3'h1;
                            if (bit_q == 3'h0) st_q <= S_ACK;
                        end
                    end
                end
                S_STOP: if (tick) begin
                    ph_q <= ph_q + 2'h1;
                    if (ph_q == 2'h0) sda_oe_q <= 1'b1;
                    if (ph_q == 2'h1) scl_oe_q <= 1'b0;
                    if (ph_q == 2'h3) begin
                        sda_oe_q <= 1'b0;
                        st_q <= S_IDLE;
                    end
                end
                default: st_q <= S_IDLE;
            endcase
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    property p_data_while_low;
        @(posedge i_clk_sys) disable iff (!i_rstn)
            (st_q == S_BIT || st_q == S_ACK) && $changed(sda_oe_q) |-> scl_oe_q;
    endproperty
    a_data_while_low: assert property (p_data_while_low)
        else $error("Data line moved while the clock line was released");

    assign o_busy = active;
    assign o_nack = nack_q;
    assign o_scl_oe = scl_oe_q;
    assign o_sda_oe = sda_oe_q;

endmodule : broadcast_enable_byte_tx

/* design/charge_parameter_broadcast.sv */
// Autonomous broadcaster of charge current and voltage set-points to a charger
//
// What this block does
// - Voltage value is unsigned millivolts, zero to 65,534.
// - Current value is unsigned milliamperes, zero to 65,534.
// - Sixteen-bit values go out low byte first.
// - Frame is address-write, register code, low byte, high byte, optional PEC.
// - Charger PEC enable appends a PEC byte to charger writes.
// - With both PEC enables cleared no PEC byte is ever sent.
// - Host PEC enable has no effect on frames to the charger.
// - I2C variant keeps the frame but never sends PEC, no PEC option.
// - I2C variant writes values straight into charger registers, no setup.
// - Use broadcasts only when this gauge is the sole bus master.
// - Precharge uses precharge switch when option clear, charge switch when set.
// - Broadcast enable gates the start of each sequence; cleared means no new sequence starts.
// - SMBus variant targets address 0x12, repeating every 10 s, within the 10 s to 60 s window.
// - I2C variant takes address, period and register codes from settings.
`timescale 1ns/1ns
module charge_parameter_broadcast
    import broadcast_enable_pkg::*;
#(
    parameter longint PERIOD_CYC = SMB_PERIOD_CYC,
    parameter logic [15:0] QTR_CYC = QTR_CNT
) (
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rstn,
    // Configuration
    input wire logic i_broadcast_enable,
    input wire logic i_charger_pec_enable,
    input wire logic i_host_pec_enable,
    input wire logic i_i2c_variant,
    input wire logic i_precharge_common_switch,
    input wire logic [6:0] i_cfg_charger_addr,
    input wire logic [7:0] i_cfg_voltage_reg,
    input wire logic [7:0] i_cfg_current_reg,
    input wire logic [31:0] i_cfg_period_cyc,
    // Set-points
    input wire logic [15:0] i_charge_voltage,
    input wire logic [15:0] i_charge_current,
    input wire logic i_precharge,
    input wire logic i_charge_allowed,
    // Switch controls
    output logic o_charge_switch_on,
    output logic o_precharge_switch_on,
    // Status
    output logic o_frame_busy,
    output logic o_frame_done,
    output logic o_frame_nack,
    // Bus pins
    input wire logic i_scl,
    input wire logic i_sda,
    output logic o_scl_oe,
    output logic o_sda_oe
);
    // ****************************************
    // Sequencer
    // ****************************************
    typedef enum logic [5:0] {
        Q_IDLE = 6'h01, Q_START = 6'h02, Q_BYTE = 6'h04,
        Q_WAIT = 6'h08, Q_STOP = 6'h10, Q_DONE = 6'h20
    } seq_e;

    seq_e seq_q;
    logic [31:0] per_q;
    logic second_q;
    logic [2:0] idx_q;
    logic [7:0] crc_q;
    logic [15:0] val_q;
    logic done_q;
    logic nack_q;
    logic chg_q;
    logic pchg_q;
    logic eng_busy;
    logic eng_nack;

    // SMBus variant is fixed at 0x12 and a 10 s pace inside the 10..60 s window
    wire [6:0] addr = i_i2c_variant ? i_cfg_charger_addr : SMB_CHARGER_ADDR;
    wire [31:0] period = i_i2c_variant ? i_cfg_period_cyc : 32'(PERIOD_CYC);
    wire [7:0] code_v = i_i2c_variant ? i_cfg_voltage_reg : CMD_VOLTAGE;
    wire [7:0] code_c = i_i2c_variant ? i_cfg_current_reg : CMD_CURRENT;
    // Host PEC enable deliberately unused: there are no host frames here
    wire pec_on = i_charger_pec_enable && !i_i2c_variant;
    // Values above the ceiling are clamped to stay in range
    wire [15:0] v_clip = (i_charge_voltage > VALUE_MAX) ? VALUE_MAX : i_charge_voltage;
    wire [15:0] c_clip = (i_charge_current > VALUE_MAX) ? VALUE_MAX : i_charge_current;
    wire [2:0] last_idx = pec_on ? 3'h4 : 3'h3;
    wire [7:0] tx_byte = (idx_q == 3'h0) ? {addr, 1'b0} :
                         (idx_q == 3'h1) ? (second_q ? code_c : code_v) :
                         (idx_q == 3'h2) ? val_q[7:0] :
                         (idx_q == 3'h3) ? val_q[15:8] : crc_q;
    wire due = (per_q == 32'h0);
    wire eng_start = (seq_q == Q_START);
    wire eng_send = (seq_q == Q_BYTE);
    wire eng_stop = (seq_q == Q_STOP);

    function automatic logic [7:0] crc8_step(input logic [7:0] c, input logic [7:0] d);
        logic [7:0] r;
        r = c ^ d;
        for (int i = 0; i < 8; i++) begin
            r = r[7] ? ((r << 1) ^ CRC8_POLY) : (r << 1);
        end
        return r;
    endfunction : crc8_step

    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            per_q <= 32'h0;
        end else if (!i_broadcast_enable) begin
            per_q <= 32'h0;
        end else if (seq_q == Q_IDLE && due) begin
            per_q <= period - 32'h1;
        end else if (!due) begin
            per_q <= per_q - 32'h1;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            seq_q <= Q_IDLE;
            second_q <= 1'b0;
            idx_q <= 3'h0;
            crc_q <= 8'h00;
            val_q <= 16'h0000;
            done_q <= 1'b0;
            nack_q <= 1'b0;
        end else begin
            done_q <= 1'b0;
            case (seq_q)
                Q_IDLE: begin
                    second_q <= 1'b0;
                    // A cleared enable holds the sequencer here
                    if (i_broadcast_enable && due) begin
                        seq_q <= Q_START;
                        val_q <= v_clip;
                        nack_q <= 1'b0;
                    end
                end
                // Index 7 marks a start condition with no byte sent yet
                Q_START: begin
                    idx_q <= 3'h7;
                    crc_q <= 8'h00;
                    seq_q <= Q_WAIT;
                end
                Q_BYTE: seq_q <= Q_WAIT;
                Q_WAIT: if (!eng_busy) begin
                    if (idx_q == 3'h7) begin
                        idx_q <= 3'h0;
                        seq_q <= Q_BYTE;
                    end else begin
                        // Byte just sent is still selected by the index
                        crc_q <= crc8_step(crc_q, tx_byte);
                        if (eng_nack) nack_q <= 1'b1;
                        if (idx_q == last_idx || eng_nack) begin
                            seq_q <= Q_STOP;
                        end else begin
                            idx_q <= idx_q + 3'h1;
                            seq_q <= Q_BYTE;
                        end
                    end
                end
                Q_STOP: seq_q <= Q_DONE;
                Q_DONE: if (!eng_busy) begin
                    if (!second_q) begin
                        second_q <= 1'b1;
                        val_q <= c_clip;
                        seq_q <= Q_START;
                    end else begin
                        done_q <= 1'b1;
                        seq_q <= Q_IDLE;
                    end
                end
                default: seq_q <= Q_IDLE;
            endcase
        end
    end

    // ****************************************
    // Sequencer checks
    // ****************************************
    property p_idle_disabled;
        @(posedge i_clk_sys) disable iff (!i_rstn)
            seq_q == Q_IDLE && !i_broadcast_enable |=> seq_q == Q_IDLE;
    endproperty
    a_idle_disabled: assert property (p_idle_disabled)
        else $error("Sequence started with broadcasts disabled");

    property p_smb_address;
        @(posedge i_clk_sys) disable iff (!i_rstn)
            seq_q == Q_BYTE && idx_q == 3'h0 && !i_i2c_variant
                |-> tx_byte == {SMB_CHARGER_ADDR, 1'b0};
    endproperty
    a_smb_address: assert property (p_smb_address)
        else $error("SMBus frame not aimed at the fixed charger address");

    property p_no_pec_cleared;
        @(posedge i_clk_sys) disable iff (!i_rstn)
            seq_q == Q_BYTE && !i_charger_pec_enable |-> idx_q <= 3'h3;
    endproperty
    a_no_pec_cleared: assert property (p_no_pec_cleared)
        else $error("Check byte sent with the charger check disabled");

    property p_i2c_no_pec;
        @(posedge i_clk_sys) disable iff (!i_rstn)
            seq_q == Q_BYTE && i_i2c_variant |-> idx_q <= 3'h3;
    endproperty
    a_i2c_no_pec: assert property (p_i2c_no_pec)
        else $error("Check byte sent in the two-wire variant");

    property p_pec_follows;
        @(posedge i_clk_sys) disable iff (!i_rstn)
            seq_q == Q_WAIT && !eng_busy && idx_q == 3'h3 && pec_on && !eng_nack
                |=> seq_q == Q_BYTE && idx_q == 3'h4;
    endproperty
    a_pec_follows: assert property (p_pec_follows)
        else $error("Check byte missing after the high data byte");

    property p_value_range;
        @(posedge i_clk_sys) disable iff (!i_rstn)
            seq_q == Q_BYTE |-> val_q <= VALUE_MAX;
    endproperty
    a_value_range: assert property (p_value_range)
        else $error("Set-point above the allowed ceiling");

    broadcast_enable_byte_tx #(
        .QTR_CYC(QTR_CYC)
    ) u_tx (
        .i_clk_sys(i_clk_sys),
        .i_rstn(i_rstn),
        .i_start(eng_start),
        .i_send(eng_send),
        .i_stop(eng_stop),
        .i_byte(tx_byte),
        .o_busy(eng_busy),
        .o_nack(eng_nack),
        .i_scl(i_scl),
        .i_sda(i_sda),
        .o_scl_oe(o_scl_oe),
        .o_sda_oe(o_sda_oe)
    );

    // ****************************************
    // Precharge switch selection
    // ****************************************
    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            chg_q <= 1'b0;
            pchg_q <= 1'b0;
        end else begin
            chg_q <= i_charge_allowed && (!i_precharge || i_precharge_common_switch);
            pchg_q <= i_charge_allowed && i_precharge && !i_precharge_common_switch;
        end
    end

    property p_switch_select;
        @(posedge i_clk_sys) disable iff (!i_rstn)
            i_charge_allowed && i_precharge && !i_precharge_common_switch
                |=> o_precharge_switch_on && !o_charge_switch_on;
    endproperty
    a_switch_select: assert property (p_switch_select)
        else $error("Precharge did not use the precharge switch");

    assign o_charge_switch_on = chg_q;
    assign o_precharge_switch_on = pchg_q;
    assign o_frame_busy = (seq_q != Q_IDLE);
    assign o_frame_done = done_q;
    assign o_frame_nack = nack_q;

endmodule : charge_parameter_broadcast

/* tb/charger_model.sv */
// Behavioural charger on the two-wire bus: acknowledges bytes, logs frames, holds set-points
`timescale 1ns/1ns
module charger_model
    import broadcast_enable_pkg::*;
(
    // Resolved bus levels
    input wire logic i_scl,
    input wire logic i_sda,
    // Data line pull-down
    output logic o_sda_oe
);
    logic [7:0] shift_q;
    logic [7:0] frame[$];
    logic [7:0] log[$];
    logic [15:0] volt_reg;
    logic [15:0] curr_reg;
    int nbit;

    initial begin
        o_sda_oe = 1'b0;
        nbit = 0;
        volt_reg = 16'h0000;
        curr_reg = 16'h0000;
    end

    // ****************************************
    // Framing
    // ****************************************
    always @(negedge i_sda) if (i_scl === 1'b1) begin
        nbit = 0;
        frame.delete();
    end

    // Whole two-byte registers are overwritten, nothing else kept in them
    always @(posedge i_sda) if (i_scl === 1'b1) begin
        log = {log, frame};
        if (frame.size() >= 4 && frame[1] == CMD_CURRENT) curr_reg = {frame[3], frame[2]};
        if (frame.size() >= 4 && frame[1] == CMD_VOLTAGE) volt_reg = {frame[3], frame[2]};
    end

    // ****************************************
    // Bits and acknowledge
    // ****************************************
    always @(posedge i_scl) if (nbit < 8) begin
        shift_q = {shift_q[6:0], i_sda};
        nbit++;
    end

    // Line released after the ninth clock, so the pull-up shows again
    always @(negedge i_scl) begin
        if (nbit == 8) begin
            o_sda_oe <= 1'b1;
            frame.push_back(shift_q);
            nbit = 9;
        end else if (nbit == 9) begin
            o_sda_oe <= 1'b0;
            nbit = 0;
        end
    end
endmodule : charger_model

/* tb/charge_parameter_broadcast_test.sv */
// Self-checking bench for the charge parameter broadcaster
`timescale 1ns/1ns
module charge_parameter_broadcast_test;
    import broadcast_enable_pkg::*;
    logic i_clk_sys, i_rstn, en, charger_pec_enable, host_pec_enable, i2c, pcc, pre, allow;
    logic [6:0] caddr;
    logic [7:0] vreg, creg;
    logic [31:0] per;
    logic [15:0] volt, curr;
    logic chg_on, pre_on, busy, done, nack, scl_oe, sda_oe, chg_sda_oe;
    wire scl = ~scl_oe;
    wire sda = ~(sda_oe | chg_sda_oe);
    int n_fail, comparisons, bad;
    logic [7:0] exp_q[$];

    charge_parameter_broadcast #(.PERIOD_CYC(20000), .QTR_CYC(16'h0008)) i_dut (
        .i_clk_sys(i_clk_sys), .i_rstn(i_rstn), .i_broadcast_enable(en),
        .i_charger_pec_enable(charger_pec_enable),
        .i_host_pec_enable(host_pec_enable), .i_i2c_variant(i2c), .i_precharge_common_switch(pcc),
        .i_cfg_charger_addr(caddr), .i_cfg_voltage_reg(vreg), .i_cfg_current_reg(creg),
        .i_cfg_period_cyc(per), .i_charge_voltage(volt), .i_charge_current(curr),
        .i_precharge(pre), .i_charge_allowed(allow), .o_charge_switch_on(chg_on),
        .o_precharge_switch_on(pre_on), .o_frame_busy(busy), .o_frame_done(done),
        .o_frame_nack(nack), .i_scl(scl), .i_sda(sda), .o_scl_oe(scl_oe), .o_sda_oe(sda_oe));
    charger_model i_chg (.i_scl(scl), .i_sda(sda), .o_sda_oe(chg_sda_oe));

    initial begin
        i_clk_sys = 1'b0;
        forever #2 i_clk_sys = ~i_clk_sys;
    end

    // ****************************************
    // Helpers
    // ****************************************
    task automatic check(string what, logic [15:0] exp, logic [15:0] got);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    function automatic logic [7:0] crc8(logic [7:0] q[$]);
        logic [7:0] c;
        c = 8'h00;
        foreach (q[i]) begin
            c ^= q[i];
            for (int b = 0; b < 8; b++) c = c[7] ? ((c << 1) ^ CRC8_POLY) : (c << 1);
        end
        return c;
    endfunction : crc8

    function automatic logic [15:0] clamp(logic [15:0] v);
        return (v > VALUE_MAX) ? VALUE_MAX : v;
    endfunction : clamp

    task automatic add_frame(logic [6:0] a, logic [7:0] code, logic [15:0] v, logic pec);
        logic [7:0] f[$];
        logic [15:0] c;
        c = clamp(v);
        f = '{{a, 1'b0}, code, c[7:0], c[15:8]};
        if (pec) f.push_back(crc8(f));
        exp_q = {exp_q, f};
    endtask : add_frame

    // One enabled sequence, then the logged bytes against the expected frames
    task automatic run_seq(logic [15:0] v, logic [15:0] c);
        int k;
        @(posedge i_clk_sys);
        volt <= v;
        curr <= c;
        repeat (4) @(posedge i_clk_sys);
        i_chg.log.delete();
        exp_q.delete();
        en <= 1'b1;
        k = 0;
        while (done !== 1'b1 && k < 20000) begin
            @(posedge i_clk_sys);
            k++;
        end
        en <= 1'b0;
        check("sequence finished", 16'h0001, 16'(k < 20000));
        repeat (10) @(posedge i_clk_sys);
        check("nack flag", 16'h0000, 16'(nack));
        if (i2c) begin
            add_frame(caddr, vreg, v, 1'b0);
            add_frame(caddr, creg, c, 1'b0);
        end else begin
            add_frame(SMB_CHARGER_ADDR, CMD_VOLTAGE, v, charger_pec_enable);
            add_frame(SMB_CHARGER_ADDR, CMD_CURRENT, c, charger_pec_enable);
            check("charger voltage", clamp(v), i_chg.volt_reg);
            check("charger current", clamp(c), i_chg.curr_reg);
        end
        check("byte count", 16'(exp_q.size()), 16'(i_chg.log.size()));
        foreach (exp_q[i]) if (i < i_chg.log.size()) check("frame byte", exp_q[i], i_chg.log[i]);
    endtask : run_seq

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : conclude

    initial begin
        // One sequence of about 3,050 cycles and three of about 2,450, plus idle checks
        #400000;
        n_fail++;
        conclude();
    end

    // ****************************************
    // Scenarios
    // ****************************************
    initial begin
        {en, charger_pec_enable, host_pec_enable, i2c, pcc, pre, allow} = 7'h00;
        {caddr, vreg, creg, volt, curr} = '0;
        per = 32'd20000;
        i_rstn = 1'b0;
        n_fail = 0;
        comparisons = 0;
        bad = 0;
        void'($urandom(32'h16FD5567));
        repeat (12) @(posedge i_clk_sys);
        i_rstn <= 1'b1;
        // Enable low: lines and status stay idle well past a start delay
        repeat (3000) begin
            @(posedge i_clk_sys);
            if (scl_oe !== 1'b0 || sda_oe !== 1'b0 || busy !== 1'b0) bad++;
        end
        check("idle while disabled", 16'h0000, 16'(bad));
        charger_pec_enable <= 1'b1;
        run_seq(16'hFFFF, 16'($urandom_range(0, 65534)));
        charger_pec_enable <= 1'b0;
        host_pec_enable <= 1'b1;
        run_seq(16'($urandom_range(0, 65534)), 16'h0000);
        host_pec_enable <= 1'b0;
        run_seq(16'($urandom_range(0, 65534)), 16'($urandom));
        i2c <= 1'b1;
        charger_pec_enable <= 1'b1;
        caddr <= 7'($urandom_range(8, 119));
        vreg <= 8'($urandom_range(0, 127));
        creg <= 8'($urandom_range(128, 255));
        run_seq(16'($urandom), 16'($urandom_range(0, 65534)));
        pre <= 1'b1;
        allow <= 1'b1;
        for (int s = 0; s < 2; s++) begin
            pcc <= 1'(s);
            repeat (5) @(posedge i_clk_sys);
            check("charge switch", 16'(s), 16'(chg_on));
            check("precharge switch", 16'(1 - s), 16'(pre_on));
        end
        pre <= 1'b0;
        repeat (3) @(posedge i_clk_sys);
        check("charge switch", 16'h0001, 16'(chg_on));
        check("precharge switch", 16'h0000, 16'(pre_on));
        conclude();
    end
endmodule : charge_parameter_broadcast_test
